// file: cie_core.sv
// Execution core for a subset of the 8-bit instruction set
`timescale 1ns/100ps
`default_nettype none
module cie_core (
	input  wire logic                         core_clk_i,
	input  wire logic                         sys_rst_i,
	input  wire logic                         instr_valid_i,
	input  wire logic [cie_pkg::OP_W-1:0]     instr_i,
	input  wire logic [cie_pkg::DATA_W-1:0]   file_rdata_i,
	input  wire logic [7:0]                   page_latch_i,
	input  wire logic                         wake_i,
	output logic [cie_pkg::FADDR_W-1:0]       file_raddr_o,
	output cie_pkg::cie_fwr_t                 file_wr_o,
	output logic [cie_pkg::DATA_W-1:0]        accum_o,
	output logic [7:0]                        status_o,
	output logic [cie_pkg::PC_W-1:0]          pc_o,
	output logic                              global_irq_allow_o,
	output logic                              instr_ready_o,
	output logic                              watchdog_clr_o,
	output logic                              osc_stop_o,
	output logic                              illegal_o
);
	localparam int SP_W = $clog2(cie_pkg::STACK_D);

	function automatic cie_pkg::cie_op_t decode(input logic [13:0] op);
		decode = cie_pkg::CIE_OP_ILLEGAL;
		if (op == cie_pkg::OP_IDLE) decode = cie_pkg::CIE_OP_IDLE;
		else if (op == cie_pkg::OP_RETURN) decode = cie_pkg::CIE_OP_RETURN;
		else if (op == cie_pkg::OP_IRQ_EXIT) decode = cie_pkg::CIE_OP_IRQ_EXIT;
		else if (op == cie_pkg::OP_SLEEP) decode = cie_pkg::CIE_OP_SLEEP;
		else if (op[13:7] == {cie_pkg::OP6_STORE, 1'b1})
			decode = cie_pkg::CIE_OP_STORE;
		else if (op[13:8] == cie_pkg::OP6_MOVE) decode = cie_pkg::CIE_OP_MOVE;
		else if (op[13:8] == cie_pkg::OP6_ROT_R) decode = cie_pkg::CIE_OP_ROT_R;
		else if (op[13:8] == cie_pkg::OP6_ROT_L) decode = cie_pkg::CIE_OP_ROT_L;
		else if (op[13:10] == cie_pkg::OP4_LOAD_LIT)
			decode = cie_pkg::CIE_OP_LOAD_LIT; // Bits 9:8 don't care [RULE4]
		else if (op[13:10] == cie_pkg::OP4_RET_LIT)
			decode = cie_pkg::CIE_OP_RET_LIT;
		else if (op[13:9] == cie_pkg::OP5_SUB_LIT)
			decode = cie_pkg::CIE_OP_SUB_LIT;
		else if (op[13:11] == cie_pkg::OP3_GOTO) decode = cie_pkg::CIE_OP_GOTO;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decode and datapath
	cie_pkg::cie_op_t                 op;
	logic                             dst_file;
	logic [7:0]                       lit;
	logic [7:0]                       res;
	logic [8:0]                       diff;
	logic [4:0]                       hdiff;
	logic                             take;
	logic                             sleep_r;
	logic                             stall_r;
	logic [cie_pkg::PC_W-1:0]         stack_r [cie_pkg::STACK_D];
	logic [SP_W-1:0]                  sp_r;
	logic [SP_W-1:0]                  sp_pop;

	assign op       = decode(instr_i);
	assign dst_file = instr_i[7];
	assign lit      = instr_i[7:0];
	assign file_raddr_o = instr_i[6:0];
	assign instr_ready_o = !stall_r && !sleep_r;
	assign take     = instr_valid_i && instr_ready_o;
	assign sp_pop   = sp_r - 1'b1;
	assign diff     = {1'b0, lit} - {1'b0, accum_o};      // [RULE14]
	assign hdiff    = {1'b0, lit[3:0]} - {1'b0, accum_o[3:0]};
	assign osc_stop_o = sleep_r;                           // [RULE12]

	always_comb begin
		case (op)
			cie_pkg::CIE_OP_ROT_L:
				res = {file_rdata_i[6:0], status_o[cie_pkg::ST_C]};
			cie_pkg::CIE_OP_ROT_R:
				res = {status_o[cie_pkg::ST_C], file_rdata_i[7:1]};
			cie_pkg::CIE_OP_SUB_LIT: res = diff[7:0];
			default: res = file_rdata_i;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Accumulator
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			accum_o <= 8'h00;
		end else if (take) begin
			case (op)
				cie_pkg::CIE_OP_MOVE, cie_pkg::CIE_OP_ROT_L,
				cie_pkg::CIE_OP_ROT_R: begin
					if (!dst_file) accum_o <= res;         // [RULE1] [RULE8] [RULE9]
				end
				cie_pkg::CIE_OP_LOAD_LIT: accum_o <= lit;  // [RULE3]
				cie_pkg::CIE_OP_RET_LIT: accum_o <= lit;   // [RULE7]
				cie_pkg::CIE_OP_SUB_LIT: accum_o <= res;   // [RULE14]
				default: ;
			endcase
		end
	end

	// File write port, registered one cycle after issue
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			file_wr_o <= '0;
		end else begin
			file_wr_o.we   <= 1'b0;
			file_wr_o.addr <= instr_i[6:0];
			if (take) begin
				case (op)
					cie_pkg::CIE_OP_STORE: begin
						file_wr_o.we   <= 1'b1;        // [RULE6]
						file_wr_o.data <= accum_o;
					end
					cie_pkg::CIE_OP_MOVE, cie_pkg::CIE_OP_ROT_L,
					cie_pkg::CIE_OP_ROT_R: begin
						file_wr_o.we   <= dst_file;    // [RULE1] [RULE8] [RULE9]
						file_wr_o.data <= res;
					end
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			status_o <= cie_pkg::STATUS_RST;
		end else if (take) begin
			case (op)
				cie_pkg::CIE_OP_MOVE:
					status_o[cie_pkg::ST_Z] <= (res == 8'h00);   // [RULE2]
				cie_pkg::CIE_OP_ROT_L:
					status_o[cie_pkg::ST_C] <= file_rdata_i[7];  // [RULE8]
				cie_pkg::CIE_OP_ROT_R:
					status_o[cie_pkg::ST_C] <= file_rdata_i[0];  // [RULE9]
				cie_pkg::CIE_OP_SUB_LIT: begin
					// Carry is not-borrow in this arithmetic
					status_o[cie_pkg::ST_C]    <= !diff[8];      // [RULE14]
					status_o[cie_pkg::ST_HALF] <= !hdiff[4];
					status_o[cie_pkg::ST_Z]    <= (diff[7:0] == 8'h00);
				end
				cie_pkg::CIE_OP_SLEEP: begin
					status_o[cie_pkg::ST_PWRDN] <= 1'b0;         // [RULE11]
					status_o[cie_pkg::ST_WDEXP] <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) global_irq_allow_o <= 1'b0;
		else if (take && op == cie_pkg::CIE_OP_IRQ_EXIT)
			global_irq_allow_o <= 1'b1;                         // [RULE5]
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) illegal_o <= 1'b0;
		else illegal_o <= take && op == cie_pkg::CIE_OP_ILLEGAL;
	end

	////////////////////////////////////////////////////////////////////////
	// Program counter, stack and two-cycle branches
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pc_o <= cie_pkg::PC_RST;
		end else if (take) begin
			case (op)
				cie_pkg::CIE_OP_IRQ_EXIT, cie_pkg::CIE_OP_RET_LIT,
				cie_pkg::CIE_OP_RETURN:
					pc_o <= stack_r[sp_pop];             // [RULE5] [RULE7] [RULE13]
				cie_pkg::CIE_OP_GOTO:
					pc_o <= {page_latch_i[cie_pkg::PAGE_HI:cie_pkg::PAGE_LO],
						instr_i[cie_pkg::JUMP_W-1:0]};   // [RULE16]
				default: pc_o <= pc_o + 1'b1;            // [RULE15]
			endcase
		end
	end

	// No call here: the stack is only popped; entries stay as reset
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sp_r <= '0;
			for (int i = 0; i < cie_pkg::STACK_D; i++) stack_r[i] <= '0;
		end else if (take && (op == cie_pkg::CIE_OP_IRQ_EXIT ||
				op == cie_pkg::CIE_OP_RET_LIT ||
				op == cie_pkg::CIE_OP_RETURN)) begin
			sp_r <= sp_pop;                              // [RULE13]
		end
	end

	// Branches occupy a second cycle, refused on the ready line
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) stall_r <= 1'b0;
		else stall_r <= take && (op == cie_pkg::CIE_OP_IRQ_EXIT ||
			op == cie_pkg::CIE_OP_RET_LIT || op == cie_pkg::CIE_OP_RETURN ||
			op == cie_pkg::CIE_OP_GOTO);                 // [RULE7] [RULE13] [RULE16]
	end

	////////////////////////////////////////////////////////////////////////
	// Power-down
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sleep_r        <= 1'b0;
			watchdog_clr_o <= 1'b0;
		end else begin
			watchdog_clr_o <= take && op == cie_pkg::CIE_OP_SLEEP; // [RULE10]
			if (take && op == cie_pkg::CIE_OP_SLEEP) sleep_r <= 1'b1; // [RULE12]
			else if (wake_i) sleep_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_load_acc;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_LOAD_LIT |=> accum_o == $past(lit)
			&& status_o == $past(status_o);
	endproperty
	a_load_acc: assert property (p_load_acc) else $error("literal load wrong"); // [RULE3]

	property p_move_z;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_MOVE |=>
			status_o[cie_pkg::ST_Z] == ($past(file_rdata_i) == 8'h00);
	endproperty
	a_move_z: assert property (p_move_z) else $error("move zero flag wrong"); // [RULE2]

	property p_ret_two;                                  // [RULE13]
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_RETURN |=> !instr_ready_o ##1 instr_ready_o;
	endproperty
	a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

	property p_irq_exit;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_IRQ_EXIT |=> global_irq_allow_o;
	endproperty
	a_irq_exit: assert property (p_irq_exit) else $error("irq allow not set"); // [RULE5]

	property p_sleep;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_SLEEP |=> watchdog_clr_o && osc_stop_o
			&& !status_o[cie_pkg::ST_PWRDN] && status_o[cie_pkg::ST_WDEXP];
	endproperty
	a_sleep: assert property (p_sleep) else $error("power-down entry wrong"); // [RULE11]

	property p_sub;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_SUB_LIT |=>
			accum_o == 8'($past(lit) - $past(accum_o));
	endproperty
	a_sub: assert property (p_sub) else $error("subtract result wrong"); // [RULE14]

	property p_rotl_c;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_ROT_L |=>
			status_o[cie_pkg::ST_C] == $past(file_rdata_i[7]);
	endproperty
	a_rotl_c: assert property (p_rotl_c) else $error("rotate left carry wrong"); // [RULE8]

	property p_idle;                                     // [RULE15]
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_IDLE |=> pc_o == 13'($past(pc_o) + 1)
			&& accum_o == $past(accum_o) && !file_wr_o.we;
	endproperty
	a_idle: assert property (p_idle) else $error("idle changed state");

	property p_goto;                                     // [RULE16]
		@(posedge core_clk_i) disable iff (sys_rst_i)
		take && op == cie_pkg::CIE_OP_GOTO |=> pc_o[10:0] == $past(instr_i[10:0]);
	endproperty
	a_goto: assert property (p_goto) else $error("jump target wrong");

	c_sleep: cover property (@(posedge core_clk_i) take
		&& op == cie_pkg::CIE_OP_SLEEP);
	c_ret_lit: cover property (@(posedge core_clk_i) take
		&& op == cie_pkg::CIE_OP_RET_LIT);
	c_store: cover property (@(posedge core_clk_i) take
		&& op == cie_pkg::CIE_OP_STORE);
endmodule // cie_core
`default_nettype wire

// file: cie_pkg.sv
// Package: opcode layout, flag positions and timing constants for the core
// Summary of operation
// RULE1 - move_file_instr copies file to accumulator (d=0) or file (d=1)
// RULE2 - move_file_instr sets result-null flag from moved value only
// RULE3 - load_literal_instr puts literal in accumulator, flags unchanged
// RULE4 - load_literal_instr with don't-care bits zero decodes as valid
// RULE5 - interrupt_exit_instr pops stack_top into PC, sets global_irq_allow
// RULE6 - store_accum_instr writes accumulator to file, flags unchanged
// RULE7 - return_literal_instr loads literal, pops PC, two cycles, no flags
// RULE8 - rotate_left_instr shifts left through wrap bit; d picks target
// RULE9 - rotate_right_instr shifts right through wrap bit; d picks target
// RULE10 - Power-down clears watchdog_counter and its prescaler
// RULE11 - Power-down clears powerdown_flag and sets watchdog_expiry_flag
// RULE12 - After power-down the core enters low-power state, clock stopped
// RULE13 - Subroutine return pops stack_top into PC, two cycles, no flags
// RULE14 - subtract_from_literal_instr: literal minus accum, wrap/half/Z
// RULE15 - idle_instr only advances the program counter, one cycle
// RULE16 - Jump: 11-bit literal to PC 10:0, page_latch 4:3 to PC 12:11
package cie_pkg;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W    = 13;
	localparam int OP_W    = 14;
	localparam int STACK_D = 8;
	// Status register bit positions
	localparam int ST_C   = 0;
	localparam int ST_HALF  = 1;
	localparam int ST_Z     = 2;
	localparam int ST_PWRDN = 3;
	localparam int ST_WDEXP = 4;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	// Opcode patterns
	localparam logic [13:0] OP_IDLE    = 14'h0000;
	localparam logic [13:0] OP_RETURN  = 14'h0008;
	localparam logic [13:0] OP_IRQ_EXIT  = 14'h0009;
	localparam logic [13:0] OP_SLEEP     = 14'h0063;
	localparam logic [5:0]  OP6_STORE    = 6'h00;
	localparam logic [5:0]  OP6_MOVE     = 6'h08;
	localparam logic [5:0]  OP6_ROT_R    = 6'h0c;
	localparam logic [5:0]  OP6_ROT_L    = 6'h0d;
	localparam logic [3:0]  OP4_LOAD_LIT = 4'hc;
	localparam logic [3:0]  OP4_RET_LIT  = 4'hd;
	localparam logic [4:0]  OP5_SUB_LIT  = 5'h1e;
	localparam logic [2:0]  OP3_GOTO   = 3'h5;
	localparam int PAGE_LO = 3;
	localparam int PAGE_HI = 4;
	localparam int JUMP_W  = 11;
	localparam int BRANCH_CYCLES = 2;
	typedef enum logic [3:0] {
		CIE_OP_IDLE, CIE_OP_MOVE, CIE_OP_STORE, CIE_OP_LOAD_LIT,
		CIE_OP_IRQ_EXIT, CIE_OP_RET_LIT, CIE_OP_RETURN, CIE_OP_ROT_L,
		CIE_OP_ROT_R, CIE_OP_SUB_LIT, CIE_OP_SLEEP, CIE_OP_GOTO,
		CIE_OP_ILLEGAL
	} cie_op_t;
	// File write request
	typedef struct packed {
		logic               we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0]  data;
	} cie_fwr_t;
endpackage

// file: tb_top.sv
// Self-checking testbench for the instruction execution core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic                        core_clk_i;
	logic                        sys_rst_i;
	logic                        instr_valid_i;
	logic [cie_pkg::OP_W-1:0]    instr_i;
	logic [cie_pkg::DATA_W-1:0]  file_rdata_i;
	logic [7:0]                  page_latch_i;
	logic                        wake_i;
	logic [cie_pkg::FADDR_W-1:0] file_raddr_o;
	cie_pkg::cie_fwr_t           file_wr_o;
	logic [cie_pkg::DATA_W-1:0]  accum_o;
	logic [7:0]                  status_o;
	logic [cie_pkg::PC_W-1:0]    pc_o;
	logic                        global_irq_allow_o;
	logic                        instr_ready_o;
	logic                        watchdog_clr_o;
	logic                        osc_stop_o;
	logic                        illegal_o;
	int                          err_total;
	int                          total_checks;
	logic [7:0]                  st_x;
	logic [12:0]                 pc_x;

	cie_core i_dut (
		.core_clk_i         (core_clk_i),
		.sys_rst_i          (sys_rst_i),
		.instr_valid_i      (instr_valid_i),
		.instr_i            (instr_i),
		.file_rdata_i       (file_rdata_i),
		.page_latch_i       (page_latch_i),
		.wake_i             (wake_i),
		.file_raddr_o       (file_raddr_o),
		.file_wr_o          (file_wr_o),
		.accum_o            (accum_o),
		.status_o           (status_o),
		.pc_o               (pc_o),
		.global_irq_allow_o (global_irq_allow_o),
		.instr_ready_o      (instr_ready_o),
		.watchdog_clr_o     (watchdog_clr_o),
		.osc_stop_o         (osc_stop_o),
		.illegal_o          (illegal_o)
	);

	always #2 core_clk_i = ~core_clk_i;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One instruction taken at the second edge; outputs sampled just after
	task automatic exec(input logic [13:0] op, input logic [7:0] rd);
		@(posedge core_clk_i);
		instr_valid_i <= 1'b1;
		instr_i       <= op;
		file_rdata_i  <= rd;
		@(posedge core_clk_i);
		instr_valid_i <= 1'b0;
		#1;
		pc_x = pc_x + 13'h0001;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic s_literal();
		logic [7:0] tw [4] = '{8'h05, 8'h01, 8'h3c, 8'h08};
		logic [7:0] tk [4] = '{8'h03, 8'h03, 8'h3c, 8'h10};
		logic [7:0] tr [4] = '{8'hfe, 8'h02, 8'h00, 8'h08};
		logic [2:0] tf [4] = '{3'h0, 3'h3, 3'h7, 3'h1};
		// Don't-care bits assembled as zero must still decode
		exec({cie_pkg::OP4_LOAD_LIT, 2'b00, 8'hff}, 8'h00);
		chk(accum_o, 8'hff);
		chk(status_o, st_x);
		chk(illegal_o, 1'b0);
		for (int i = 0; i < 4; i++) begin
			exec({cie_pkg::OP4_LOAD_LIT, 2'b00, tw[i]}, 8'h00);
			exec({cie_pkg::OP5_SUB_LIT, 1'b0, tk[i]}, 8'h00);
			st_x[2:0] = tf[i];
			chk(accum_o, tr[i]);
			chk(status_o, st_x);
		end
	endtask

	task automatic s_idle();
		exec(cie_pkg::OP_IDLE, 8'h00);
		chk(pc_o, pc_x);
		chk({accum_o, status_o}, {8'h08, st_x});
		chk(file_wr_o.we, 1'b0);
	endtask

	task automatic s_file();
		exec({cie_pkg::OP6_MOVE, 1'b0, 7'h7f}, 8'h00);
		st_x[cie_pkg::ST_Z] = 1'b1;
		chk(file_raddr_o, 7'h7f);
		chk(accum_o, 8'h00);
		chk(status_o, st_x);
		exec({cie_pkg::OP6_MOVE, 1'b1, 7'h15}, 8'h3c);
		st_x[cie_pkg::ST_Z] = 1'b0;
		chk(file_wr_o, {1'b1, 7'h15, 8'h3c});
		chk(accum_o, 8'h00);
		chk(status_o, st_x);
		exec({cie_pkg::OP4_LOAD_LIT, 2'b00, 8'hc3}, 8'h00);
		exec({cie_pkg::OP6_STORE, 1'b1, 7'h00}, 8'h5a);
		chk(file_wr_o, {1'b1, 7'h00, 8'hc3});
		chk(status_o, st_x);
	endtask

	task automatic s_rotate();
		// Carry enters at the vacated end, the bit shifted out becomes carry
		exec({cie_pkg::OP6_ROT_L, 1'b0, 7'h21}, 8'h81);
		chk(accum_o, {7'h01, st_x[0]});
		st_x[0] = 1'b1;
		chk(status_o, st_x);
		exec({cie_pkg::OP6_ROT_R, 1'b1, 7'h22}, 8'h02);
		chk(file_wr_o, {1'b1, 7'h22, st_x[0], 7'h01});
		st_x[0] = 1'b0;
		chk(status_o, st_x);
		chk(accum_o, 8'h03);
	endtask

	task automatic s_branch();
		page_latch_i <= 8'h10;
		exec({cie_pkg::OP3_GOTO, 11'h5a5}, 8'h00);
		chk(pc_o, 13'h15a5);
		chk(instr_ready_o, 1'b0);
		// Empty stack pops a zero entry
		exec(cie_pkg::OP_RETURN, 8'h00);
		chk(pc_o, 13'h0000);
		chk({instr_ready_o, status_o}, {1'b0, st_x});
		exec({cie_pkg::OP4_RET_LIT, 2'b00, 8'h77}, 8'h00);
		chk({pc_o, instr_ready_o}, {13'h0000, 1'b0});
		chk({accum_o, status_o}, {8'h77, st_x});
		@(posedge core_clk_i);
		#1;
		chk(instr_ready_o, 1'b1);
		exec(cie_pkg::OP_IRQ_EXIT, 8'h00);
		chk({global_irq_allow_o, pc_o}, {1'b1, 13'h0000});
		chk(status_o, st_x);
		pc_x = 13'h0000;
	endtask

	task automatic s_sleep();
		exec(cie_pkg::OP_SLEEP, 8'h00);
		st_x[cie_pkg::ST_WDEXP] = 1'b1;
		st_x[cie_pkg::ST_PWRDN] = 1'b0;
		chk(status_o, st_x);
		chk(watchdog_clr_o, 1'b1);
		chk({osc_stop_o, instr_ready_o}, 2'b10);
		@(posedge core_clk_i);
		#1;
		chk(watchdog_clr_o, 1'b0);
		chk({osc_stop_o, instr_ready_o}, 2'b10);
		@(posedge core_clk_i);
		wake_i <= 1'b1;
		@(posedge core_clk_i);
		wake_i <= 1'b0;
		for (int i = 0; i < 8 && instr_ready_o !== 1'b1; i++) begin
			@(posedge core_clk_i);
		end
		#1;
		chk({osc_stop_o, instr_ready_o}, 2'b01);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i    = 1'b0;
		sys_rst_i     = 1'b1;
		instr_valid_i = 1'b0;
		instr_i       = '0;
		file_rdata_i  = '0;
		page_latch_i  = '0;
		wake_i        = 1'b0;
		err_total     = 0;
		total_checks  = 0;
		st_x          = cie_pkg::STATUS_RST;
		pc_x          = '0;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		s_literal();
		s_idle();
		s_file();
		s_rotate();
		s_branch();
		s_sleep();
		final_report();
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		#8000;
		err_total++;
		final_report();
	end
endmodule // tb_top
`default_nettype wire
